//--- verilog/sdp_defs.svh
// Offsets, field widths, reset values and timing counts
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

`define SDP_OFS_FMT        8'h00
`define SDP_OFS_TXB        8'h04
`define SDP_OFS_RXB        8'h08
`define SDP_OFS_CTRL       8'h0C
`define SDP_OFS_STAT       8'h10
`define SDP_OFS_BRATE      8'h14

`define SDP_CTRL_W         3
`define SDP_FLG_W          7
`define SDP_FLG_CLR_W      6

`define SDP_FMT_RST        8'h00
`define SDP_TXB_RST        8'hFF
`define SDP_RXB_RST        8'h00
`define SDP_CTRL_RST       3'h0
`define SDP_FLG_RST        7'h21
`define SDP_BRATE_RST      8'hFF

`define SDP_PRE_DIV1       6'h00
`define SDP_PRE_DIV4       6'h03
`define SDP_PRE_DIV16      6'h0F
`define SDP_PRE_DIV64      6'h3F

`define SDP_PHASE_MID      4'h7
`define SDP_PHASE_LAST     4'hF
`define SDP_LAST_BIT8      3'h7
`define SDP_LAST_BIT7      3'h6
`define SDP_HSIZE_WORD     3'h2

`endif

//--- verilog/sdp_pkg.sv
// Types shared by the serial data path block
package sdp_pkg;

   typedef struct packed {
      logic sync_mode;
      logic char_length_select;
      logic parity_on;
      logic odd_parity;
      logic two_stop;
      logic multidrop_format;
      logic prescale_sel_hi;
      logic prescale_sel_lo;
   } sdp_fmt_t;

   typedef struct packed {
      logic mpb_tx;
      logic receiver_on;
      logic transmitter_on;
   } sdp_ctrl_t;

   typedef struct packed {
      logic mpb;
      logic tend;
      logic orer;
      logic fer;
      logic per;
      logic rdrf;
      logic tx_buffer_empty_flag;
   } sdp_flags_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
   } sdp_ahb_t;

   typedef enum logic [2:0] {
      T_IDLE, T_START, T_DATA, T_PAR, T_STOP
   } sdp_tx_st_t;

   typedef enum logic [2:0] {
      R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_SYNC
   } sdp_rx_st_t;

   typedef struct packed {
      sdp_tx_st_t st;
      logic [7:0] tx_shifter;
      logic [2:0] cnt;
      logic       txd;
   } sdp_tx_t;

   typedef struct packed {
      sdp_rx_st_t st;
      logic [7:0] rx_shifter;
      logic [2:0] cnt;
      logic [3:0] os;
      logic       pbit;
   } sdp_rx_t;

endpackage : sdp_pkg

//--- verilog/sdp_top.sv
// Serial data path and frame format block with AHB-Lite registers
// Contract
// R1 - Receive LSB first, auto move to buffer
// R2 - Receive shifter has no CPU access
// R3 - Shifter free again right after transfer
// R4 - Receive buffer read-only, clears to zero
// R5 - Load shifter from buffer, send LSB first
// R6 - Auto reload next byte unless buffer empty
// R7 - Transmit shifter has no CPU access
// R8 - Transmit buffer RW, resets all ones
// R9 - Format register RW, clears to zero
// R10 - Bit 7 selects async or sync
// R11 - Bit 6 selects 7 or 8 bits; code applies it in async only, sync always 8 bits
// R12 - 7-bit mode drops transmit bit 7
// R13 - Bit 5 parity only async, no multidrop
// R14 - Bit 4 even or odd parity
// R15 - Bit 3 one or two stop bits
// R16 - Receiver checks first stop bit only
// R17 - Bit 2 multidrop overrides parity, async
// R18 - Bits 1:0 select prescale 1/4/16/64
// R19 - Send after buffer write and flag clear
// R20 - Software sets format before enabling
// R21 - Async idle high, one low start bit
`timescale 1ns/1ns
`include "sdp_defs.svh"

module sdp_top
   import sdp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        low_power_clear,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rxd,
   output logic             txd,
   output logic             sck_out,
   output logic             sck_oe
);

   localparam sdp_tx_t TX_RST = '{st: T_IDLE, tx_shifter: 8'h00,
                                  cnt: 3'h0, txd: 1'b1};
   localparam sdp_rx_t RX_RST = '{st: R_IDLE, rx_shifter: 8'h00,
                                  cnt: 3'h0, os: 4'h0, pbit: 1'b0};

   // Parity over 7 or 8 data bits
   function automatic logic par_of(input logic [7:0] d,
                                   input logic       n7,
                                   input logic       odd);
      logic [7:0] m;
      m = n7 ? {1'b0, d[6:0]} : d;
      return (^m) ^ odd;
   endfunction : par_of

   // Prescaler terminal count
   function automatic logic [5:0] pre_max(input logic [1:0] sel);
      logic [5:0] v;
      case (sel)
         2'h0:    v = `SDP_PRE_DIV1;
         2'h1:    v = `SDP_PRE_DIV4;
         2'h2:    v = `SDP_PRE_DIV16;
         default: v = `SDP_PRE_DIV64;
      endcase
      return v;
   endfunction : pre_max

   // Register file
   sdp_fmt_t    frame_format_select;
   sdp_fmt_t    next_frame_format_select;
   logic [7:0]  transmit_buffer;
   logic [7:0]  next_transmit_buffer;
   logic [7:0]  receive_buffer;
   logic [7:0]  next_receive_buffer;
   sdp_ctrl_t   ctrl;
   sdp_ctrl_t   next_ctrl;
   sdp_flags_t  flg;
   sdp_flags_t  next_flg;
   logic [7:0]  brate;
   logic [7:0]  next_brate;
   sdp_ahb_t    ap;
   sdp_ahb_t    next_ap;
   logic [31:0] next_hrdata;
   logic        next_hreadyout;

   // Baud generator
   logic [5:0]  pre;
   logic [5:0]  next_pre;
   logic [7:0]  div;
   logic [7:0]  next_div;
   logic [3:0]  phase;
   logic [3:0]  next_phase;
   logic        next_sck_out;
   logic        next_sck_oe;
   logic        pre_tick;
   logic        os_tick;
   logic        bit_end;
   logic        samp_tick;

   // Receive pin conditioning
   logic [2:0]  rsync;
   logic [2:0]  next_rsync;
   logic        rx_lvl;
   logic        next_rx_lvl;

   // Shifters
   sdp_tx_t     tx;
   sdp_tx_t     next_tx;
   sdp_rx_t     rx;
   sdp_rx_t     next_rx;
   logic        tx_load;
   logic        tx_end;
   logic        try_load;
   logic        ended;
   logic        rx_done;
   logic        rx_per;
   logic        rx_fer;
   logic        rx_mpb;

   // Decoded format
   logic        async_m;
   logic        n7;
   logic        par_act;
   logic        mp_act;
   logic [2:0]  last_bit;

   // R10 mode select
   assign async_m  = !frame_format_select.sync_mode;
   // R11 length only in async
   assign n7       = async_m && frame_format_select.char_length_select;
   // R13 R17 parity gated by mode and multidrop
   assign par_act  = async_m && frame_format_select.parity_on
                     && !frame_format_select.multidrop_format;
   assign mp_act   = async_m && frame_format_select.multidrop_format;
   assign last_bit = n7 ? `SDP_LAST_BIT7 : `SDP_LAST_BIT8;

   // Bus slave and registers
   always_comb begin
      next_frame_format_select = frame_format_select;
      next_transmit_buffer     = transmit_buffer;
      next_receive_buffer      = receive_buffer;
      next_ctrl                = ctrl;
      next_flg                 = flg;
      next_brate               = brate;
      next_ap                  = '{wr: 1'b0, rd: 1'b0, addr: ap.addr};
      next_hrdata              = hrdata;
      next_hreadyout           = 1'b1;
      if (ap.wr) begin
         case (ap.addr)
            // R9 format register writable
            `SDP_OFS_FMT:   next_frame_format_select = sdp_fmt_t'(hwdata[7:0]);
            // R8 transmit buffer writable any time
            `SDP_OFS_TXB:   next_transmit_buffer = hwdata[7:0];
            `SDP_OFS_CTRL:  next_ctrl = sdp_ctrl_t'(hwdata[`SDP_CTRL_W-1:0]);
            `SDP_OFS_STAT:  next_flg = flg & sdp_flags_t'({1'b1,
                                       hwdata[`SDP_FLG_CLR_W-1:0]});
            `SDP_OFS_BRATE: next_brate = hwdata[7:0];
            // R4 receive buffer ignores writes
            default: ;
         endcase
      end
      if (ap.rd) begin
         next_hrdata = 32'h0000_0000;
         case (ap.addr)
            `SDP_OFS_FMT:   next_hrdata[7:0] = frame_format_select;
            `SDP_OFS_TXB:   next_hrdata[7:0] = transmit_buffer;
            // R2 received data only via buffer
            `SDP_OFS_RXB:   next_hrdata[7:0] = receive_buffer;
            `SDP_OFS_CTRL:  next_hrdata[`SDP_CTRL_W-1:0] = ctrl;
            `SDP_OFS_STAT:  next_hrdata[`SDP_FLG_W-1:0] = flg;
            `SDP_OFS_BRATE: next_hrdata[7:0] = brate;
            default: ;
         endcase
      end
      if (hsel && htrans[1] && hready && hsize == `SDP_HSIZE_WORD) begin
         next_ap = '{wr: hwrite, rd: !hwrite, addr: haddr[7:0]};
         next_hreadyout = hwrite;
      end
      // R6 flag set by load
      if (tx_load) begin
         next_flg.tx_buffer_empty_flag = 1'b1;
         next_flg.tend = 1'b0;
      end
      if (tx_end) begin
         next_flg.tend = 1'b1;
      end
      // R19 flag held while transmitter off
      if (!ctrl.transmitter_on) begin
         next_flg.tx_buffer_empty_flag = 1'b1;
      end
      // R1 R3 byte to buffer, shifter freed
      if (rx_done) begin
         if (next_flg.rdrf) begin
            next_flg.orer = 1'b1;
         end else begin
            next_receive_buffer = next_rx.rx_shifter;
            next_flg.rdrf = 1'b1;
            next_flg.per  = next_flg.per | rx_per;
            next_flg.fer  = next_flg.fer | rx_fer;
            next_flg.mpb  = rx_mpb;
         end
      end
      // R4 R9 clears in low-power states
      if (low_power_clear) begin
         next_frame_format_select = sdp_fmt_t'(`SDP_FMT_RST);
         next_transmit_buffer     = `SDP_TXB_RST;
         next_receive_buffer      = `SDP_RXB_RST;
         next_ctrl                = sdp_ctrl_t'(`SDP_CTRL_RST);
         next_flg                 = sdp_flags_t'(`SDP_FLG_RST);
         next_brate               = `SDP_BRATE_RST;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // R4 R8 R9 reset values
         frame_format_select <= sdp_fmt_t'(`SDP_FMT_RST);
         transmit_buffer     <= `SDP_TXB_RST;
         receive_buffer      <= `SDP_RXB_RST;
         ctrl                <= sdp_ctrl_t'(`SDP_CTRL_RST);
         flg                 <= sdp_flags_t'(`SDP_FLG_RST);
         brate               <= `SDP_BRATE_RST;
         ap                  <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
         hrdata              <= 32'h0000_0000;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
      end else begin
         frame_format_select <= next_frame_format_select;
         transmit_buffer     <= next_transmit_buffer;
         receive_buffer      <= next_receive_buffer;
         ctrl                <= next_ctrl;
         flg                 <= next_flg;
         brate               <= next_brate;
         ap                  <= next_ap;
         hrdata              <= next_hrdata;
         hreadyout           <= next_hreadyout;
         hresp               <= 1'b0;
      end
   end

   // Baud generator
   always_comb begin
      // R18 prescale select
      pre_tick  = (pre == pre_max({frame_format_select.prescale_sel_hi,
                                   frame_format_select.prescale_sel_lo}));
      os_tick   = pre_tick && (div == brate);
      next_pre  = pre_tick ? 6'h00 : pre + 6'h01;
      next_div  = div;
      if (pre_tick) begin
         next_div = os_tick ? 8'h00 : div + 8'h01;
      end
      next_phase = os_tick ? phase + 4'h1 : phase;
      bit_end    = os_tick && (phase == `SDP_PHASE_LAST);
      samp_tick  = os_tick && (phase == `SDP_PHASE_MID);
      next_sck_out = !(frame_format_select.sync_mode && !next_phase[3]
                       && (tx.st != T_IDLE || rx.st == R_SYNC));
      next_sck_oe  = frame_format_select.sync_mode;
      if (low_power_clear) begin
         next_pre   = 6'h00;
         next_div   = 8'h00;
         next_phase = 4'h0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre     <= 6'h00;
         div     <= 8'h00;
         phase   <= 4'h0;
         sck_out <= 1'b1;
         sck_oe  <= 1'b0;
      end else begin
         pre     <= next_pre;
         div     <= next_div;
         phase   <= next_phase;
         sck_out <= next_sck_out;
         sck_oe  <= next_sck_oe;
      end
   end

   // Receive pin filter
   always_comb begin
      next_rsync  = {rsync[1:0], rxd};
      next_rx_lvl = (rsync[1] == rsync[2]) ? rsync[2] : rx_lvl;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsync  <= 3'h7;
         rx_lvl <= 1'b1;
      end else begin
         rsync  <= next_rsync;
         rx_lvl <= next_rx_lvl;
      end
   end

   // Transmitter
   always_comb begin
      next_tx  = tx;
      tx_load  = 1'b0;
      tx_end   = 1'b0;
      try_load = 1'b0;
      ended    = 1'b0;
      if (bit_end) begin
         case (tx.st)
            T_IDLE: begin
               try_load = 1'b1;
            end
            T_START: begin
               next_tx.txd = tx.tx_shifter[0];
               next_tx.st  = T_DATA;
               next_tx.cnt = 3'h0;
            end
            T_DATA: begin
               // R12 last bit 6 in 7-bit mode
               if (tx.cnt == last_bit) begin
                  if (mp_act) begin
                     next_tx.txd = ctrl.mpb_tx;
                     next_tx.st  = T_PAR;
                  end else if (par_act) begin
                     // R14 parity sense
                     next_tx.txd = par_of(tx.tx_shifter, n7,
                                          frame_format_select.odd_parity);
                     next_tx.st  = T_PAR;
                  end else if (async_m) begin
                     next_tx.txd = 1'b1;
                     next_tx.st  = T_STOP;
                     next_tx.cnt = 3'h0;
                  end else begin
                     try_load = 1'b1;
                     ended    = 1'b1;
                  end
               end else begin
                  // R5 next bit upward
                  next_tx.txd = tx.tx_shifter[tx.cnt + 3'h1];
                  next_tx.cnt = tx.cnt + 3'h1;
               end
            end
            T_PAR: begin
               next_tx.txd = 1'b1;
               next_tx.st  = T_STOP;
               next_tx.cnt = 3'h0;
            end
            T_STOP: begin
               // R15 one or two stop bits
               if (frame_format_select.two_stop && tx.cnt == 3'h0) begin
                  next_tx.cnt = 3'h1;
               end else begin
                  try_load = 1'b1;
                  ended    = 1'b1;
               end
            end
            default: begin
               next_tx = TX_RST;
            end
         endcase
      end
      // R6 R19 reload only when flag clear
      if (try_load) begin
         if (ctrl.transmitter_on && !flg.tx_buffer_empty_flag) begin
            tx_load            = 1'b1;
            // R5 R7 internal copy only
            next_tx.tx_shifter = transmit_buffer;
            next_tx.cnt        = 3'h0;
            if (async_m) begin
               // R21 low start bit
               next_tx.st  = T_START;
               next_tx.txd = 1'b0;
            end else begin
               next_tx.st  = T_DATA;
               next_tx.txd = transmit_buffer[0];
            end
         end else begin
            // R21 idle high
            next_tx.st  = T_IDLE;
            next_tx.txd = 1'b1;
            tx_end      = ended;
         end
      end
      if (low_power_clear) begin
         next_tx = TX_RST;
         tx_load = 1'b0;
         tx_end  = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx  <= TX_RST;
         txd <= 1'b1;
      end else begin
         tx  <= next_tx;
         txd <= next_tx.txd;
      end
   end

   // Receiver
   always_comb begin
      next_rx = rx;
      rx_done = 1'b0;
      rx_per  = 1'b0;
      rx_fer  = 1'b0;
      rx_mpb  = 1'b0;
      if (os_tick) begin
         next_rx.os = rx.os + 4'h1;
      end
      case (rx.st)
         R_IDLE: begin
            if (!async_m) begin
               next_rx.st         = R_SYNC;
               next_rx.cnt        = 3'h0;
               next_rx.rx_shifter = 8'h00;
            end else if (os_tick && !rx_lvl) begin
               next_rx.st = R_START;
               next_rx.os = 4'h0;
            end
         end
         R_START: begin
            if (os_tick && rx.os == `SDP_PHASE_MID) begin
               next_rx.os         = 4'h0;
               next_rx.cnt        = 3'h0;
               next_rx.rx_shifter = 8'h00;
               next_rx.st         = rx_lvl ? R_IDLE : R_DATA;
            end
         end
         R_DATA: begin
            if (os_tick && rx.os == `SDP_PHASE_LAST) begin
               // R1 LSB first into shifter
               next_rx.rx_shifter[rx.cnt] = rx_lvl;
               next_rx.cnt = rx.cnt + 3'h1;
               if (rx.cnt == last_bit) begin
                  next_rx.st = (par_act || mp_act) ? R_PAR : R_STOP;
               end
            end
         end
         R_PAR: begin
            if (os_tick && rx.os == `SDP_PHASE_LAST) begin
               next_rx.pbit = rx_lvl;
               next_rx.st   = R_STOP;
            end
         end
         R_STOP: begin
            // R16 first stop bit only
            if (os_tick && rx.os == `SDP_PHASE_LAST) begin
               rx_done    = 1'b1;
               rx_fer     = !rx_lvl;
               // R14 receive parity check
               rx_per     = par_act && (rx.pbit != par_of(rx.rx_shifter, n7,
                               frame_format_select.odd_parity));
               rx_mpb     = mp_act && rx.pbit;
               next_rx.st = R_IDLE;
            end
         end
         R_SYNC: begin
            if (async_m) begin
               next_rx.st = R_IDLE;
            end else if (samp_tick) begin
               next_rx.rx_shifter[rx.cnt] = rx_lvl;
               next_rx.cnt = rx.cnt + 3'h1;
               rx_done     = (rx.cnt == `SDP_LAST_BIT8);
            end
         end
         default: begin
            next_rx = RX_RST;
         end
      endcase
      if (!ctrl.receiver_on || low_power_clear) begin
         next_rx = RX_RST;
         rx_done = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx <= RX_RST;
      end else begin
         rx <= next_rx;
      end
   end

endmodule : sdp_top

//--- tb/sdp_assertions.sv
// Port checker for the serial data path block
`timescale 1ns/1ns
module sdp_assertions (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        low_power_clear,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        sck_out,
   input wire logic        sck_oe
);
   logic taken;
   logic fmt_wr_q;
   logic want_sync;
   assign taken = hsel && htrans[1] && hready && (hsize == 3'h2);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fmt_wr_q  <= 1'b0;
         want_sync <= 1'b0;
      end else begin
         fmt_wr_q <= taken && hwrite && (haddr[7:0] == 8'h00);
         if (fmt_wr_q) begin
            want_sync <= hwdata[7];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   rd_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (taken && hwrite |=> hreadyout)
      else $error("write stalled");
   rxb_width_a: assert property (taken && !hwrite && haddr[7:0] == 8'h08
      |-> ##2 (hrdata[31:8] == 24'h0)) else $error("receive buffer wider than a byte");
   mode_oe_a: assert property (fmt_wr_q |-> ##[1:2] (sck_oe == want_sync))
      else $error("clock enable does not follow mode bit");
   sck_idle_a: assert property (!sck_oe && !$past(sck_oe) && !$past(sck_oe, 2)
      |-> sck_out) else $error("serial clock active in async mode");
   start_len_a: assert property ($fell(txd) |=> !txd [*8])
      else $error("start bit too short");
   stop_len_a: assert property ($rose(txd) |=> txd [*8])
      else $error("high bit too short");
   lp_clear_a: assert property (low_power_clear [*3] |-> (txd && !sck_oe))
      else $error("low power clear ineffective");
   resp_okay_a: assert property (!hresp)
      else $error("error response given");
   cover property (taken && !hwrite);
   cover property ($fell(txd));
   cover property ($rose(sck_oe));
endmodule : sdp_assertions

bind sdp_top sdp_assertions u_chk (.clk, .rstn, .low_power_clear, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .sck_out, .sck_oe);

//--- tb/sdp_peer.sv
// Remote asynchronous serial peer model
`timescale 1ns/1ns
module sdp_peer (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   int          bitlen = 16;
   int          nbits  = 10;
   logic [11:0] seen [$];
   logic [11:0] v;
   initial rxd = 1'b1;
   always begin
      @(negedge txd);
      v = 12'h000;
      repeat (bitlen / 2) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         v[i] = txd;
         if (i < nbits - 1) repeat (bitlen) @(posedge clk);
      end
      seen.push_back(v);
   end
   // low start, data lsb first, high stop
   task automatic send(input logic [7:0] d);
      for (int i = 0; i < 10; i++) begin
         rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
         repeat (bitlen) @(posedge clk);
      end
   endtask : send
endmodule : sdp_peer

//--- tb/tb.sv
// Self-checking bench for the serial data path block
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        low_power_clear, hsel, hwrite, hready, hreadyout, hresp;
   logic        rxd, txd, sck_out, sck_oe;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [7:0]  fmts [9] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h24, 8'h01, 8'h02, 8'h03};
   logic [7:0]  dats [9] = '{8'hA5, 8'h25, 8'h07, 8'h07, 8'h5A, 8'h81, 8'h33, 8'hC6, 8'h3C};
   always #25 clk = ~clk;
   assign hready = hreadyout;
   sdp_top DUT (.clk, .rstn, .low_power_clear, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .sck_out, .sck_oe);
   sdp_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask : ahb
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      chk("register", e, q);
   endtask : rc
   task automatic poll(input int b);
      int k;
      k = 0;
      do begin
         ahb(8'h10, 1'b0, 32'h0);
         k++;
      end while (q[b] !== 1'b1 && k < 3000);
   endtask : poll
   function automatic logic [11:0] want(input logic [7:0] f, input logic [7:0] d,
                                        output int n);
      logic [11:0] v;
      v = 12'h000;
      n = 1;
      for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
         v[n] = d[i];
         n++;
      end
      if (f[5] || f[2]) begin
         v[n] = f[2] ? 1'b1 : (^(f[6] ? {1'b0, d[6:0]} : d)) ^ f[4];
         n++;
      end
      v[n] = 1'b1;
      n    = n + 1 + f[3];
      if (f[3]) v[n - 1] = 1'b1;
      return v;
   endfunction : want
   task automatic tx_one(input logic [7:0] f, input logic [7:0] d);
      int n;
      int k;
      logic [11:0] e;
      e = want(f, d, n);
      ahb(8'h0C, 1'b1, 32'h0);
      ahb(8'h00, 1'b1, {24'h0, f});
      ahb(8'h0C, 1'b1, 32'h5);
      peer.bitlen = 16 << (2 * f[1:0]);
      peer.nbits  = n;
      ahb(8'h04, 1'b1, {24'h0, d});
      ahb(8'h10, 1'b1, 32'h3E);
      k = 0;
      while (peer.seen.size() == 0 && k < 20000) begin
         @(posedge clk);
         k++;
      end
      chk("frame", {20'h0, e}, {20'h0, peer.seen.pop_front()});
   endtask : tx_one
   task automatic t_regs();
      rc(8'h00, 32'h0);
      rc(8'h04, 32'hFF);
      ahb(8'h08, 1'b1, 32'h55);
      rc(8'h08, 32'h0);
      ahb(8'h00, 1'b1, 32'hA5);
      rc(8'h00, 32'hA5);
      ahb(8'h04, 1'b1, 32'h3C);
      rc(8'h04, 32'h3C);
      rc(8'h18, 32'h0);
      ahb(8'h00, 1'b1, 32'h5A);
      low_power_clear <= 1'b1;
      repeat (3) @(posedge clk);
      low_power_clear <= 1'b0;
      rc(8'h00, 32'h0);
      rc(8'h04, 32'hFF);
   endtask : t_regs
   task automatic t_b2b();
      int k;
      tx_one(8'h08, 8'h0F);
      ahb(8'h04, 1'b1, 32'h11);
      ahb(8'h10, 1'b1, 32'h3E);
      poll(0);
      ahb(8'h04, 1'b1, 32'h22);
      ahb(8'h10, 1'b1, 32'h3E);
      k = 0;
      while (peer.seen.size() < 2 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      chk("first", 32'h622, {20'h0, peer.seen.pop_front()});
      chk("second", 32'h644, {20'h0, peer.seen.pop_front()});
   endtask : t_b2b
   task automatic t_gate();
      ahb(8'h0C, 1'b1, 32'h0);
      ahb(8'h04, 1'b1, 32'h77);
      ahb(8'h10, 1'b1, 32'h3E);
      ahb(8'h10, 1'b0, 32'h0);
      chk("empty flag", 32'h1, {31'h0, q[0]});
      repeat (400) @(posedge clk);
      chk("idle line", 32'h0, peer.seen.size());
   endtask : t_gate
   // clocked mode, sampled on clock rise
   task automatic t_sync();
      logic [7:0] s;
      ahb(8'h0C, 1'b1, 32'h0);
      ahb(8'h00, 1'b1, 32'h80);
      ahb(8'h0C, 1'b1, 32'h1);
      ahb(8'h04, 1'b1, 32'h96);
      ahb(8'h10, 1'b1, 32'h3E);
      for (int i = 0; i < 8; i++) begin
         @(posedge sck_out);
         s[i] = txd;
      end
      chk("sync data", 32'h96, {24'h0, s});
   endtask : t_sync
   task automatic t_rx();
      ahb(8'h00, 1'b1, 32'h08);
      ahb(8'h0C, 1'b1, 32'h2);
      peer.bitlen = 16;
      fork
         begin
            peer.send(8'h3C);
            peer.send(8'hC5);
         end
      join_none
      poll(1);
      rc(8'h08, 32'h3C);
      ahb(8'h10, 1'b1, 32'h3D);
      poll(1);
      rc(8'h08, 32'hC5);
      ahb(8'h10, 1'b0, 32'h0);
      chk("errors", 32'h0, {30'h0, q[4:3]});
   endtask : t_rx
   initial begin
      {low_power_clear, hwrite} = 2'h0;
      hsel   = 1'b1;
      hsize  = 3'h2;
      htrans = 2'h0;
      haddr  = 32'h0;
      hwdata = 32'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      ahb(8'h14, 1'b1, 32'h0);
      for (int i = 0; i < 9; i++) begin
         tx_one(fmts[i], dats[i]);
      end
      t_b2b();
      t_gate();
      t_sync();
      t_rx();
      wrap_up();
   end
endmodule : tb
